// ---- rtl/common_signals_params.svh ----
// Notes on behaviour
// - Common start/trip rise when any enabled stage raises its start/trip.
// - Extra inputs, selected per bit by mask, also drive common start/trip.
// - Each edge of either common output posts an ON/OFF event, ms stamp.
// - Separate start and trip counters, each cleared on software request.
// - Force select start/trip acts only while forcing is enabled; select normal forces nothing and stages still drive.
// - Configuration is static, unaffected by setting group changes.
// - Read-only condition: 0 normal, 1 start, 2 trip, from outputs.
// - No blocking input; suppression belongs inside each stage.
// - Per event, store ON only, OFF only, or both, by user selection.
// - Each stored event carries process data captured at the change.
`ifndef COMMON_SIGNALS_PARAMS_SVH
`define COMMON_SIGNALS_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_EVT_SELECT  8'h04
`define OFS_EXTRA_START 8'h08
`define OFS_EXTRA_TRIP  8'h0c
`define OFS_STAGE_EN    8'h10
`define OFS_STATUS      8'h14
`define OFS_START_COUNT 8'h18
`define OFS_TRIP_COUNT  8'h1c
`define OFS_TIMESTAMP   8'h20
`define OFS_EVT_FLAGS   8'h28
`define OFS_EVT_TIME    8'h2c
`define OFS_EVT_DATA    8'h30
`define OFS_EVT_POP     8'h34

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_FORCE_EN   0
`define CTRL_SEL_LO     1
`define CTRL_CLR_START  4
`define CTRL_CLR_TRIP   5
`define CTRL_CLR_OVF    6
`define EVSEL_START_ON  0
`define EVSEL_START_OFF 1
`define EVSEL_TRIP_ON   2
`define EVSEL_TRIP_OFF  3
`define STAT_START      2
`define STAT_TRIP       3
`define STAT_AVAIL      4
`define STAT_OVF        5
`define EVFLAGS_VALID   31

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RST_EVT_SELECT  4'hf
`define RST_STAGE_EN    32'hffffffff
`define TICK_TIME_NS    1000000
`define CLK_PERIOD_NS   5

`endif

// ---- rtl/common_signals_pkg.sv ----
package common_signals_pkg;
   // Condition codes as displayed; forced select uses the same codes
   typedef enum logic [1:0] {
      COND_NORMAL,
      COND_START,
      COND_TRIP
   } cond_t;
   typedef logic [3:0] ev_flags_t;
endpackage

// ---- rtl/mem_port_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if #(parameter int W = 68, parameter int AW = 4);
   logic          we;
   logic [AW-1:0] waddr;
   logic [W-1:0]  wdata;
   logic [AW-1:0] raddr;
   logic [W-1:0]  rdata;
   modport ctrl (output we, waddr, wdata, raddr, input rdata);
   modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ---- rtl/event_record_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_record_mem #(
   parameter int W  = 68,
   parameter int AW = 4
) (
   // Clock
   input wire logic mclk,
   input wire logic ce,
   // Port
   mem_port_if.mem  port
);
   logic [W-1:0] store [2**AW];

   always_ff @(posedge mclk) begin
      if (ce && port.we) begin
         store[port.waddr] <= port.wdata;
      end
   end

   // Registered read keeps the record output glitch free
   always_ff @(posedge mclk) begin
      if (ce) begin
         port.rdata <= store[port.raddr];
      end
   end
endmodule // event_record_mem
`default_nettype wire

// ---- rtl/common_signals.sv ----
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "common_signals_params.svh"
module common_signals
   import common_signals_pkg::*;
#(
   parameter int NSTAGE      = 32,
   parameter int NEXTRA      = 32,
   parameter int PDW         = 32,
   parameter int EVAW        = 4,
   parameter int TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              ce,
   // Protection stages and extra inputs
   input  wire logic [NSTAGE-1:0] stageStart,
   input  wire logic [NSTAGE-1:0] stageTrip,
   input  wire logic [NEXTRA-1:0] extraStart,
   input  wire logic [NEXTRA-1:0] extraTrip,
   input  wire logic [PDW-1:0]    processData,
   // Common outputs
   output logic                   commonStart,
   output logic                   commonTrip,
   output cond_t                  condition,
   // AXI4-Lite slave
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam int RW = 4 + 32 + PDW;
   localparam logic [EVAW:0] DEPTH = (EVAW+1)'(2**EVAW);
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   function automatic logic [31:0] satInc(input logic [31:0] v);
      return (v == 32'hffffffff) ? v : v + 32'h1;
   endfunction

   function automatic logic [31:0] wMerge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // Register bus
   // ****************************************************************
   logic              awHeld_reg;
   logic              wHeld_reg;
   logic [7:0]        awAddr_reg;
   logic [31:0]       wData_reg;
   logic [3:0]        wStrb_reg;
   logic              doWrite;
   logic              forceEn_reg;
   logic [1:0]        forceSel_reg;
   ev_flags_t         evSelect_reg;
   logic [NEXTRA-1:0] extraStartEn_reg;
   logic [NEXTRA-1:0] extraTripEn_reg;
   logic [NSTAGE-1:0] stageEn_reg;
   logic              clrStart;
   logic              clrTrip;
   logic              clrOvf;
   logic              popReq;
   logic [31:0]       rdMux;

   assign s_axi_awready = !awHeld_reg && ce;
   assign s_axi_wready  = !wHeld_reg && ce;
   assign s_axi_arready = !s_axi_rvalid && ce;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_rresp   = 2'h0;
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

   always_ff @(posedge mclk) begin
      if (reset) begin
         awHeld_reg   <= 1'b0;
         wHeld_reg    <= 1'b0;
         awAddr_reg   <= 8'h0;
         wData_reg    <= 32'h0;
         wStrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_reg <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Settings stay put across setting group changes; nothing else loads them
   always_ff @(posedge mclk) begin
      if (reset) begin
         forceEn_reg      <= 1'b0;
         forceSel_reg     <= 2'h0;
         evSelect_reg     <= `RST_EVT_SELECT;
         extraStartEn_reg <= '0;
         extraTripEn_reg  <= '0;
         stageEn_reg      <= NSTAGE'(`RST_STAGE_EN);
      end else if (ce && doWrite) begin
         unique case (awAddr_reg)
            `OFS_CTRL: begin
               if (wStrb_reg[0]) begin
                  forceEn_reg  <= wData_reg[`CTRL_FORCE_EN];
                  forceSel_reg <= wData_reg[`CTRL_SEL_LO +: 2];
               end
            end
            `OFS_EVT_SELECT: begin
               if (wStrb_reg[0]) begin
                  evSelect_reg <= wData_reg[3:0];
               end
            end
            `OFS_EXTRA_START: begin
               extraStartEn_reg <= NEXTRA'(wMerge(32'(extraStartEn_reg),
                                          wData_reg, wStrb_reg));
            end
            `OFS_EXTRA_TRIP: begin
               extraTripEn_reg <= NEXTRA'(wMerge(32'(extraTripEn_reg),
                                         wData_reg, wStrb_reg));
            end
            `OFS_STAGE_EN: begin
               stageEn_reg <= NSTAGE'(wMerge(32'(stageEn_reg),
                                     wData_reg, wStrb_reg));
            end
            default: begin
            end
         endcase
      end
   end

   // Write-one pulses; the pop pulse fires on any write to OFS_EVT_POP
   assign clrStart = doWrite && awAddr_reg == `OFS_CTRL && wStrb_reg[0]
                     && wData_reg[`CTRL_CLR_START];
   assign clrTrip  = doWrite && awAddr_reg == `OFS_CTRL && wStrb_reg[0]
                     && wData_reg[`CTRL_CLR_TRIP];
   assign clrOvf   = doWrite && awAddr_reg == `OFS_CTRL && wStrb_reg[0]
                     && wData_reg[`CTRL_CLR_OVF];
   assign popReq   = doWrite && awAddr_reg == `OFS_EVT_POP;

   // ****************************************************************
   // Aggregation
   // ****************************************************************
   logic        anyStart;
   logic        anyTrip;
   logic        forceStart;
   logic        forceTrip;
   logic        startNext;
   logic        tripNext;
   logic        startRise;
   logic        tripRise;
   logic [31:0] startCount_reg;
   logic [31:0] tripCount_reg;

   // No blocking term here; stages gate their own outputs
   assign anyStart = |(stageStart & stageEn_reg)
                     || |(extraStart & extraStartEn_reg);
   assign anyTrip  = |(stageTrip & stageEn_reg)
                     || |(extraTrip & extraTripEn_reg);
   assign forceStart = forceEn_reg && forceSel_reg == COND_START;
   assign forceTrip  = forceEn_reg && forceSel_reg == COND_TRIP;
   assign startNext  = anyStart || forceStart;
   assign tripNext   = anyTrip || forceTrip;
   assign startRise  = startNext && !commonStart;
   assign tripRise   = tripNext && !commonTrip;

   always_ff @(posedge mclk) begin
      if (reset) begin
         commonStart <= 1'b0;
         commonTrip  <= 1'b0;
         condition   <= COND_NORMAL;
      end else if (ce) begin
         commonStart <= startNext;
         commonTrip  <= tripNext;
         condition   <= tripNext  ? COND_TRIP :
                        startNext ? COND_START : COND_NORMAL;
      end
   end

   // A clear in the same cycle as an edge still counts that edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         startCount_reg <= 32'h0;
         tripCount_reg  <= 32'h0;
      end else if (ce) begin
         if (startRise) begin
            startCount_reg <= clrStart ? 32'h1
                                       : satInc(startCount_reg);
         end else if (clrStart) begin
            startCount_reg <= 32'h0;
         end
         if (tripRise) begin
            tripCount_reg <= clrTrip ? 32'h1 : satInc(tripCount_reg);
         end else if (clrTrip) begin
            tripCount_reg <= 32'h0;
         end
      end
   end

   // ****************************************************************
   // Timestamp and event buffer
   // ****************************************************************
   logic [31:0] tick_reg;
   logic [31:0] msTime_reg;
   ev_flags_t   rawFlags;
   ev_flags_t   evFlags;
   logic        evWrite;
   logic        bufFull;
   logic        doPop;
   logic [EVAW-1:0] head_reg;
   logic [EVAW-1:0] tail_reg;
   logic [EVAW:0]   count_reg;
   logic        ovf_reg;
   logic        stale_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         tick_reg   <= 32'h0;
         msTime_reg <= 32'h0;
      end else if (ce) begin
         if (tick_reg == TICK_LAST) begin
            tick_reg   <= 32'h0;
            msTime_reg <= msTime_reg + 32'h1;
         end else begin
            tick_reg <= tick_reg + 32'h1;
         end
      end
   end

   assign rawFlags = {!tripNext && commonTrip, tripRise,
                      !startNext && commonStart, startRise};
   assign evFlags  = rawFlags & evSelect_reg;
   assign bufFull  = count_reg == DEPTH;
   assign doPop    = popReq && count_reg != '0;
   // Newest event is dropped when full; software sees the overflow flag
   assign evWrite  = |evFlags && !bufFull;

   mem_port_if #(.W(RW), .AW(EVAW)) memPort ();
   assign memPort.we    = evWrite && ce;
   assign memPort.waddr = head_reg;
   assign memPort.wdata = {evFlags, msTime_reg, processData};
   assign memPort.raddr = tail_reg;

   event_record_mem #(.W(RW), .AW(EVAW)) recordMem (
      .mclk (mclk),
      .ce   (ce),
      .port (memPort)
   );

   always_ff @(posedge mclk) begin
      if (reset) begin
         head_reg  <= '0;
         tail_reg  <= '0;
         count_reg <= '0;
         ovf_reg   <= 1'b0;
         stale_reg <= 1'b0;
      end else if (ce) begin
         if (evWrite) begin
            head_reg <= head_reg + 1'b1;
         end
         if (doPop) begin
            tail_reg <= tail_reg + 1'b1;
         end
         if (evWrite && !doPop) begin
            count_reg <= count_reg + 1'b1;
         end else if (doPop && !evWrite) begin
            count_reg <= count_reg - 1'b1;
         end
         // Overflow set beats its clear
         if (|evFlags && bufFull) begin
            ovf_reg <= 1'b1;
         end else if (clrOvf) begin
            ovf_reg <= 1'b0;
         end
         // Read record lags a write or pop by one cycle; hide it meanwhile
         stale_reg <= evWrite || doPop;
      end
   end

   // ****************************************************************
   // Read side
   // ****************************************************************
   logic avail;
   assign avail = count_reg != '0 && !stale_reg;

   always_comb begin
      rdMux = 32'h0;
      unique case (s_axi_araddr)
         `OFS_CTRL: begin
            rdMux[`CTRL_FORCE_EN]    = forceEn_reg;
            rdMux[`CTRL_SEL_LO +: 2] = forceSel_reg;
         end
         `OFS_EVT_SELECT:  rdMux[3:0] = evSelect_reg;
         `OFS_EXTRA_START: rdMux = 32'(extraStartEn_reg);
         `OFS_EXTRA_TRIP:  rdMux = 32'(extraTripEn_reg);
         `OFS_STAGE_EN:    rdMux = 32'(stageEn_reg);
         `OFS_STATUS: begin
            rdMux[1:0]         = condition;
            rdMux[`STAT_START] = commonStart;
            rdMux[`STAT_TRIP]  = commonTrip;
            rdMux[`STAT_AVAIL] = avail;
            rdMux[`STAT_OVF]   = ovf_reg;
         end
         `OFS_START_COUNT: rdMux = startCount_reg;
         `OFS_TRIP_COUNT:  rdMux = tripCount_reg;
         `OFS_TIMESTAMP:   rdMux = msTime_reg;
         `OFS_EVT_FLAGS: begin
            rdMux[`EVFLAGS_VALID] = avail;
            rdMux[3:0] = avail ? memPort.rdata[RW-1 -: 4] : 4'h0;
         end
         `OFS_EVT_TIME: rdMux = memPort.rdata[PDW +: 32];
         `OFS_EVT_DATA: rdMux = 32'(memPort.rdata[PDW-1:0]);
         default: rdMux = 32'h0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset || !ce);

   property p_stage_start;
      |(stageStart & stageEn_reg) |=> commonStart;
   endproperty
   a_stage_start: assert property (p_stage_start)
      else $error("enabled stage start did not raise common start");

   property p_stage_trip;
      |(stageTrip & stageEn_reg) |=> commonTrip;
   endproperty
   a_stage_trip: assert property (p_stage_trip)
      else $error("enabled stage trip did not raise common trip");

   property p_extra_trip;
      |(extraTrip & extraTripEn_reg) |=> commonTrip;
   endproperty
   a_extra_trip: assert property (p_extra_trip)
      else $error("assigned extra trip did not raise common trip");

   property p_force;
      forceEn_reg && forceSel_reg == COND_TRIP && !anyStart && !anyTrip
         |=> commonTrip && !commonStart;
   endproperty
   a_force: assert property (p_force)
      else $error("forced trip not applied as expected");

   property p_idle;
      !anyStart && !(forceEn_reg && forceSel_reg == COND_START)
         |=> !commonStart;
   endproperty
   a_idle: assert property (p_idle)
      else $error("common start high without cause");

   property p_cond;
      condition == (commonTrip ? COND_TRIP :
                    commonStart ? COND_START : COND_NORMAL);
   endproperty
   a_cond: assert property (p_cond)
      else $error("condition does not match common outputs");

   property p_count;
      $rose(commonStart) && $past(startCount_reg) != 32'hffffffff
         && !$past(clrStart) |-> startCount_reg == $past(startCount_reg) + 1;
   endproperty
   a_count: assert property (p_count)
      else $error("start counter did not step on rising edge");

   property p_clear;
      clrTrip && !tripRise |=> tripCount_reg == 32'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("trip counter not cleared");

   property p_event;
      startRise && evSelect_reg[`EVSEL_START_ON] && !bufFull
         |=> count_reg == $past(count_reg) + 1'b1 || $past(doPop);
   endproperty
   a_event: assert property (p_event)
      else $error("start ON event not posted");

   property p_select;
      startRise && !evSelect_reg[`EVSEL_START_ON] && tripNext == commonTrip
         |=> count_reg == $past(count_reg) - $past(doPop);
   endproperty
   a_select: assert property (p_select)
      else $error("unselected event stored");

   c_start: cover property (startRise ##[1:20] !startNext);
   c_trip:  cover property (tripRise && startRise);
   c_full:  cover property (bufFull && |evFlags);
   c_pop:   cover property (doPop && evWrite);
endmodule // common_signals
`default_nettype wire

// ---- verif/stage_driver_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Far side: protection stages answering after a chosen lag
// ****************************************************************
module stage_driver_model (
   // Clock
   input  wire logic        mclk,
   // Requested stage levels and lag in cycles
   input  wire logic [31:0] wantStart,
   input  wire logic [31:0] wantTrip,
   input  wire logic [1:0]  lag,
   // Stage outputs
   output logic [31:0]      stageStart,
   output logic [31:0]      stageTrip
);
   logic [31:0] pipeS [4];
   logic [31:0] pipeT [4];

   // Stages have no blocking path through the aggregator
   always_ff @(posedge mclk) begin
      pipeS <= '{wantStart, pipeS[0], pipeS[1], pipeS[2]};
      pipeT <= '{wantTrip, pipeT[0], pipeT[1], pipeT[2]};
   end

   assign stageStart = pipeS[lag];
   assign stageTrip  = pipeT[lag];
endmodule // stage_driver_model
`default_nettype wire

// ---- verif/common_signals_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "common_signals_params.svh"
module common_signals_tb_top;
   import common_signals_pkg::*;
   logic        mclk = 0, reset = 1, awv = 0, wv = 0, bre = 0, arv = 0;
   localparam int TICK = 20;
   logic        rre = 0, ce = 1, awr, wr, bv, arr, rv, cs, ct;
   logic [31:0] wantS = 0, wantT = 0, exS = 0, exT = 0, pd = 0, wd = 0;
   logic [31:0] rd, rdata, stS, stT, en, ms, mt, s, t;
   logic [7:0]  awa = 0, ara = 0;
   logic [1:0]  lag = 0, br, rr;
   logic        es, et;
   cond_t       cond;
   integer      seed = 32'hd4f7;
   int          mismatches = 0, n_compared = 0, n;
   logic [31:0] fv [4] = '{32'h2, 32'h3, 32'h5, 32'h7};

   always #2.5 mclk = ~mclk;

   stage_driver_model far_u (.mclk(mclk), .wantStart(wantS),
      .wantTrip(wantT), .lag(lag), .stageStart(stS), .stageTrip(stT));

   common_signals #(.TICK_CYCLES(TICK)) dut_u (.mclk(mclk), .reset(reset),
      .ce(ce), .stageStart(stS), .stageTrip(stT), .extraStart(exS),
      .extraTrip(exT), .processData(pd), .commonStart(cs),
      .commonTrip(ct), .condition(cond), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rre));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] sp();
      sp = $random(seed) & $random(seed) & $random(seed) & $random(seed);
   endfunction

   function automatic cond_t ec(input logic a, input logic b);
      ec = b ? COND_TRIP : (a ? COND_START : COND_NORMAL);
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      bit aw = 0, w = 0, b = 0;
      int k = 0;
      @(posedge mclk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
      while (!b && k < 100) begin
         @(posedge mclk);
         k++;
         if (!aw && awr) begin aw = 1; awv <= 0; end
         if (!w && wr) begin w = 1; wv <= 0; end
         if (bv) begin
            b = 1;
            bre <= 0;
            chk("bresp", br, 0);
         end
      end
      if (!b) chk("bvalid", 0, 1);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      bit ar = 0, r = 0;
      int k = 0;
      @(posedge mclk);
      ara <= a; arv <= 1; rre <= 1;
      while (!r && k < 100) begin
         @(posedge mclk);
         k++;
         if (!ar && arr) begin ar = 1; arv <= 0; end
         if (rv) begin
            r = 1;
            d = rdata;
            rre <= 0;
            chk("rresp", rr, 0);
         end
      end
      if (!r) chk("rvalid", 0, 1);
   endtask

   // Lag plus far-side register plus one aggregation cycle
   task automatic settle(input logic [31:0] a, b);
      @(posedge mclk);
      wantS <= a; wantT <= b;
      repeat (7) @(posedge mclk);
   endtask

   task automatic conclude;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      conclude;
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (5) @(posedge mclk);
      reset <= 0;
      axr(`OFS_STAGE_EN, rd); chk("stage_en", rd, `RST_STAGE_EN);
      axr(`OFS_EVT_SELECT, rd); chk("evt_sel", rd, 32'hf);
      axr(8'h3c, rd); chk("unmapped", rd, 0);
      pd <= $random(seed);
      settle(1, 0);
      axr(`OFS_EVT_FLAGS, rd); chk("evt_flags", rd, 32'h80000001);
      axr(`OFS_EVT_DATA, rd); chk("evt_data", rd, pd);
      axw(`OFS_EVT_POP, 0);
      // Keep OFF only: start falls with trip rising in the same cycle
      axw(`OFS_EVT_SELECT, 32'ha);
      settle(0, 1);
      settle(0, 0);
      axr(`OFS_EVT_FLAGS, rd); chk("evt_off", rd, 32'h80000002);
      axw(`OFS_EVT_POP, 0);
      axr(`OFS_EVT_FLAGS, rd); chk("evt_trip", rd, 32'h80000008);
      axw(`OFS_EVT_POP, 0);
      axr(`OFS_EVT_FLAGS, rd); chk("evt_empty", rd >> 31, 0);
      axw(`OFS_CTRL, 32'h30);
      n = ($random(seed) & 3) + 1;
      repeat (n) begin
         settle(1, 1);
         settle(0, 0);
      end
      axr(`OFS_START_COUNT, rd); chk("start_cnt", rd, n);
      axr(`OFS_TRIP_COUNT, rd); chk("trip_cnt", rd, n);
      axw(`OFS_CTRL, 32'h10);
      axr(`OFS_START_COUNT, rd); chk("start_clr", rd, 0);
      axr(`OFS_TRIP_COUNT, rd); chk("trip_kept", rd, n);
      repeat (12) begin
         en = $random(seed); ms = $random(seed); mt = $random(seed);
         axw(`OFS_STAGE_EN, en);
         axw(`OFS_EXTRA_START, ms);
         axw(`OFS_EXTRA_TRIP, mt);
         s = sp(); t = sp();
         lag <= 2'($random(seed));
         exS <= sp(); exT <= sp();
         settle(s, t);
         es = |(s & en) | |(exS & ms);
         et = |(t & en) | |(exT & mt);
         chk("start", cs, es);
         chk("trip", ct, et);
         chk("cond", 32'(cond), 32'(ec(es, et)));
      end
      axw(`OFS_STAGE_EN, 0);
      exS <= 0; exT <= 0;
      for (int i = 0; i < 4; i++) begin
         axw(`OFS_CTRL, fv[i]);
         es = (i == 1); et = (i == 2);
         repeat (3) @(posedge mclk);
         chk("f_start", cs, es);
         chk("f_trip", ct, et);
         axr(`OFS_STATUS, rd);
         chk("status", rd & 32'hf, {et, es, 2'(ec(es, et))});
      end
      // Samples 200 cycles apart, 40 of them frozen by the clock enable
      axr(`OFS_TIMESTAMP, s);
      repeat (77) @(posedge mclk);
      ce <= 0;
      repeat (40) @(posedge mclk);
      ce <= 1;
      repeat (80) @(posedge mclk);
      axr(`OFS_TIMESTAMP, t);
      chk("ms_time", t - s, (200 - 40) / TICK);
      conclude;
   end
endmodule // common_signals_tb_top
`default_nettype wire
